/* rtl/pwc_pkg.sv */
/*
 * constants, types and helpers of the pwm period and duty channel.
 * assumes one 100 MHz clock and a plain strobe register port.
 */
// Function
// - a combined write carries a new period and a new duty, the duty running 0x0000 to 0x8000.
// - period and duty of a combined write take effect together as one pair.
// - with end-of-period update selected a new period is applied only when the running one ends.
// - with end-of-period update selected, changing period and duty never makes a pulse or notch shorter than old or new settings give.
// - a period change is honoured only on variable-period channels, else the set period stays.
// - a zero period ignores the duty and holds the output low.
// - a set-to-idle command drives the output to the idle level at once.
// - an idle variable-period channel resumes only on a combined write, with the new period.
// - an idle fixed-period channel resumes only on a duty-only write, with its old period.
// - 0% duty holds the inverse of the polarity, 100% duty holds the polarity level.
// - duty strictly between 0% and 100% modulates from period, duty and polarity.
package pwc_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] PWC_OFS_CTRL = 8'h00;
    localparam logic [7:0] PWC_OFS_PAIR = 8'h04;
    localparam logic [7:0] PWC_OFS_DUTY = 8'h08;
    localparam logic [7:0] PWC_OFS_IDLE = 8'h0C;
    localparam logic [7:0] PWC_OFS_STAT = 8'h10;

    // ----------------------------------------
    // control fields
    // ----------------------------------------
    localparam int PWC_CTL_VARPER = 0;
    localparam int PWC_CTL_DEFER = 1;
    localparam int PWC_CTL_POL = 2;
    localparam int PWC_CTL_IDLELVL = 3;
    localparam int PWC_CTL_PAIREN = 4;
    localparam int PWC_CTL_IDLEEN = 5;
    localparam int PWC_CTL_W = 6;
    localparam logic [5:0] PWC_CTL_RST = 6'h34;

    // ----------------------------------------
    // pair fields and reset values
    // ----------------------------------------
    localparam int PWC_PER_LSB = 16;
    localparam logic [15:0] PWC_DUTY_FULL = 16'h8000;
    localparam int PWC_DUTY_SHIFT = 15;
    localparam logic [15:0] PWC_FIXED_PERIOD = 16'h0064;
    localparam logic [15:0] PWC_RST_DUTY = 16'h0000;

    typedef enum logic {PWC_RUN = 1'b0, PWC_IDLE = 1'b1} pwc_mode_t;

    // clamp to the legal duty range
    function automatic logic [15:0] pwc_clamp(input logic [15:0] duty);
        pwc_clamp = (duty > PWC_DUTY_FULL) ? PWC_DUTY_FULL : duty;
    endfunction

endpackage

/* rtl/pwc_scale.sv */
/*
 * active-time scaler: period times duty over full duty.
 * assumes duty already clamped to full duty or less.
 */
`timescale 1ns/10ps
`default_nettype none
module pwc_scale
    import pwc_pkg::*;
(
    input wire logic [15:0] period,
    input wire logic [15:0] duty,
    output logic [15:0] high_time
);
    logic [31:0] prod;

    // ----------------------------------------
    // scaling
    // ----------------------------------------
    always_comb begin
        prod = {16'h0000, period} * {16'h0000, duty};
        high_time = prod[PWC_DUTY_SHIFT +: 16];
    end
endmodule
`default_nettype wire

/* rtl/pwc_channel.sv */
/*
 * one pwm channel with combined period and duty update and idle command.
 * assumes a master that keeps the strobe port protocol, one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none
module pwc_channel
    import pwc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [31:0] rdata,
    output logic pwm_out
);
    logic [PWC_CTL_W-1:0] ctrl_q, ctrl_d;
    logic [15:0] per_q, per_d, high_q, high_d, cnt_q, cnt_d;
    logic [15:0] pend_per_q, pend_per_d, pend_high_q, pend_high_d;
    logic pend_q, pend_d, out_q, out_d;
    pwc_mode_t mode_q, mode_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] w_duty, w_per, w_high;
    logic var_per, pair_wr, duty_wr, idle_cmd, at_end, apply, quiet;

    assign var_per = ctrl_q[PWC_CTL_VARPER];
    assign pair_wr = wr_stb && addr == PWC_OFS_PAIR && ctrl_q[PWC_CTL_PAIREN];
    assign duty_wr = wr_stb && addr == PWC_OFS_DUTY;
    assign idle_cmd = wr_stb && addr == PWC_OFS_IDLE && ctrl_q[PWC_CTL_IDLEEN];
    assign w_duty = pwc_clamp(wdata[15:0]);
    // fixed channels keep the set period, duty writes reuse the old one
    assign w_per = (pair_wr && var_per) ? wdata[PWC_PER_LSB +: 16]
                 : (var_per ? per_q : PWC_FIXED_PERIOD);

    pwc_scale u_scale (
        .period(w_per),
        .duty(w_duty),
        .high_time(w_high)
    );

    // ----------------------------------------
    // update timing
    // ----------------------------------------
    assign at_end = (per_q == 16'h0000) || (cnt_q >= per_q - 16'h0001);
    // inactive phase under both settings: safe to switch early
    assign quiet = cnt_q >= high_q && cnt_q >= pend_high_q && cnt_q < pend_per_q;
    assign apply = pend_q && (mode_q == PWC_IDLE || at_end
                 || (!ctrl_q[PWC_CTL_DEFER] && quiet));

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        per_d = per_q;
        high_d = high_q;
        cnt_d = at_end ? 16'h0000 : cnt_q + 16'h0001;
        pend_per_d = pend_per_q;
        pend_high_d = pend_high_q;
        pend_d = pend_q;
        mode_d = mode_q;
        if (wr_stb && addr == PWC_OFS_CTRL) begin
            ctrl_d = wdata[PWC_CTL_W-1:0];
        end
        if (apply) begin
            per_d = pend_per_q;
            high_d = pend_high_q;
            pend_d = 1'b0;
            if (per_q != pend_per_q) begin
                cnt_d = 16'h0000;
            end
        end
        if (pair_wr || duty_wr) begin
            pend_per_d = w_per;
            pend_high_d = w_high;
            pend_d = 1'b1;
        end
        if (idle_cmd) begin
            mode_d = PWC_IDLE;
        end else if (mode_q == PWC_IDLE && ((pair_wr && var_per) || (duty_wr && !var_per))) begin
            // resume on the new pair, loaded at once
            mode_d = PWC_RUN;
            per_d = w_per;
            high_d = w_high;
            pend_d = 1'b0;
            cnt_d = 16'h0000;
        end
        if (mode_d == PWC_IDLE) begin
            out_d = ctrl_d[PWC_CTL_IDLELVL];
        end else if (per_d == 16'h0000) begin
            out_d = 1'b0;
        end else if (high_d == 16'h0000) begin
            out_d = !ctrl_d[PWC_CTL_POL];
        end else if (high_d >= per_d) begin
            out_d = ctrl_d[PWC_CTL_POL];
        end else begin
            out_d = (cnt_d < high_d) ? ctrl_d[PWC_CTL_POL] : !ctrl_d[PWC_CTL_POL];
        end
        rdata_d = 32'h0000_0000;
        if (rd_stb) begin
            unique case (addr)
                PWC_OFS_CTRL: rdata_d = {26'h0, ctrl_q};
                PWC_OFS_PAIR: rdata_d = {per_q, high_q};
                PWC_OFS_STAT: rdata_d = {29'h0, out_q, mode_q, pend_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ctrl_q <= PWC_CTL_RST;
            per_q <= PWC_FIXED_PERIOD;
            high_q <= PWC_RST_DUTY;
            cnt_q <= 16'h0000;
            pend_per_q <= PWC_FIXED_PERIOD;
            pend_high_q <= PWC_RST_DUTY;
            pend_q <= 1'b0;
            mode_q <= PWC_RUN;
            out_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ctrl_q <= ctrl_d;
            per_q <= per_d;
            high_q <= high_d;
            cnt_q <= cnt_d;
            pend_per_q <= pend_per_d;
            pend_high_q <= pend_high_d;
            pend_q <= pend_d;
            mode_q <= mode_d;
            out_q <= out_d;
            rdata_q <= rdata_d;
        end
    end

    assign pwm_out = out_q;
    assign rdata = rdata_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence idle_req_s;
        idle_cmd ##1 !wr_stb;
    endsequence
    sequence resume_fixed_s;
        mode_q == PWC_IDLE && duty_wr && !var_per;
    endsequence

    idle_at_once_a: assert property (idle_req_s |-> mode_q == PWC_IDLE
        && pwm_out == ctrl_q[PWC_CTL_IDLELVL]) else $error("idle not at once");
    zero_period_a: assert property (mode_q == PWC_RUN && per_q == 16'h0000 |-> !pwm_out)
        else $error("zero period output not low");
    fixed_period_a: assert property (apply && !var_per && !wr_stb |=> per_q == PWC_FIXED_PERIOD
        || $past(pend_per_q) == per_q) else $error("fixed period changed");
    defer_hold_a: assert property (pend_q && ctrl_q[PWC_CTL_DEFER] && !at_end
        && mode_q == PWC_RUN && !wr_stb |=> per_q == $past(per_q))
        else $error("period applied early");
    pair_load_a: assert property (apply && !wr_stb |=> per_q == $past(pend_per_q)
        && high_q == $past(pend_high_q)) else $error("pair split");
    full_duty_a: assert property (mode_q == PWC_RUN && per_q != 16'h0000 && high_q >= per_q
        |-> pwm_out == ctrl_q[PWC_CTL_POL]) else $error("full duty level wrong");
    var_stay_a: assert property (mode_q == PWC_IDLE && duty_wr && var_per
        |=> mode_q == PWC_IDLE) else $error("variable channel woke on duty");
    fixed_stay_a: assert property (mode_q == PWC_IDLE && pair_wr && !var_per
        |=> mode_q == PWC_IDLE) else $error("fixed channel woke on pair");
    fixed_wake_a: assert property (resume_fixed_s and !idle_cmd |=> mode_q == PWC_RUN
        && per_q == $past(per_q)) else $error("fixed resume lost period");
    duty_range_a: assert property (pair_wr |=> pend_high_q <= pend_per_q)
        else $error("active time above period");
    modulate_a: assert property (mode_q == PWC_RUN && high_q != 16'h0000 && high_q < per_q
        && cnt_q < high_q |-> pwm_out == ctrl_q[PWC_CTL_POL])
        else $error("active phase level wrong");
    quiet_switch_a: assert property (apply && !at_end && mode_q == PWC_RUN
        |-> cnt_q >= high_q && cnt_q >= pend_high_q) else $error("switch in active phase");
endmodule
`default_nettype wire

/* bench/pwc_load.sv */
/*
 * load model on the pwm output: measures the last whole high and low runs.
 * assumes one clock shared with the channel, sync active high reset.
 */
`timescale 1ns/10ps
`default_nettype none
module pwc_load (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic pwm_in,
    output logic [15:0] hi_len,
    output logic [15:0] lo_len
);
    // ----------------------------------------
    // run length capture
    // ----------------------------------------
    logic [15:0] run_q;
    logic lvl_q;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            run_q <= 16'h0001;
            lvl_q <= 1'b0;
            hi_len <= 16'h0000;
            lo_len <= 16'h0000;
        end else if (pwm_in !== lvl_q) begin
            if (lvl_q) begin
                hi_len <= run_q;
            end else begin
                lo_len <= run_q;
            end
            lvl_q <= pwm_in;
            run_q <= 16'h0001;
        end else begin
            run_q <= run_q + 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* bench/pwc_channel_test.sv */
/*
 * self-checking bench of the pwm channel through its strobe register port.
 * assumes the register map and control bits of pwc_pkg.
 */
`timescale 1ns/10ps
`default_nettype none
module pwc_channel_test;
    import pwc_pkg::*;
    logic ref_clk = 1'b0, srst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic pwm_out;
    logic [15:0] hi_len, lo_len;
    int err_total = 0, checked = 0, cyc = 0;

    pwc_channel pwc_channel_inst (.ref_clk(ref_clk), .srst(srst), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .pwm_out(pwm_out));
    pwc_load pwc_load_inst (.ref_clk(ref_clk), .srst(srst), .pwm_in(pwm_out),
        .hi_len(hi_len), .lo_len(lo_len));

    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_total = err_total + 1;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked = checked + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic runs(input logic [15:0] hi, input logic [15:0] lo);
        chk("high run", {16'h0000, hi_len}, {16'h0000, hi});
        chk("low run", {16'h0000, lo_len}, {16'h0000, lo});
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        logic [31:0] d;
        wt(8);
        srst <= 1'b0;
        wt(2);
        rd(PWC_OFS_STAT, d);
        chk("status after reset", d, 32'h0000_0000);
        rd(PWC_OFS_CTRL, d);
        chk("ctrl reset", d, {26'h0, PWC_CTL_RST});
        rd(8'h14, d);
        chk("unmapped read", d, 32'h0000_0000);
        wr(PWC_OFS_CTRL, 32'h0000_003D);
        wr(PWC_OFS_PAIR, 32'h0004_4000);
        wt(120);
        runs(16'h0002, 16'h0002);
        rd(PWC_OFS_PAIR, d);
        chk("active pair", d, 32'h0004_0002);
        wr(PWC_OFS_PAIR, 32'h000A_8000);
        wt(30);
        chk("full duty", {31'h0, pwm_out}, 32'h1);
        wr(PWC_OFS_PAIR, 32'h000A_9000);
        wt(30);
        chk("clamped duty", {31'h0, pwm_out}, 32'h1);
        wr(PWC_OFS_PAIR, 32'h0000_4000);
        wt(30);
        chk("zero period", {31'h0, pwm_out}, 32'h0);
        wt(20);
        chk("zero period held", {31'h0, pwm_out}, 32'h0);
        wr(PWC_OFS_PAIR, 32'h0008_0000);
        wt(20);
        chk("zero duty", {31'h0, pwm_out}, 32'h0);
        wr(PWC_OFS_IDLE, 32'h0000_0000);
        #1;
        chk("idle at once", {31'h0, pwm_out}, 32'h1);
        rd(PWC_OFS_STAT, d);
        chk("idle status", d, 32'h0000_0006);
        wr(PWC_OFS_DUTY, 32'h0000_0000);
        wt(30);
        chk("variable stays idle", {31'h0, pwm_out}, 32'h1);
        wr(PWC_OFS_PAIR, 32'h0006_4000);
        wt(40);
        runs(16'h0003, 16'h0003);
        wr(PWC_OFS_CTRL, 32'h0000_003C);
        wr(PWC_OFS_PAIR, 32'h0004_4000);
        wt(350);
        runs(16'h0032, 16'h0032);
        wr(PWC_OFS_IDLE, 32'h0000_0000);
        wr(PWC_OFS_PAIR, 32'h0004_0000);
        wt(200);
        chk("fixed stays idle", {31'h0, pwm_out}, 32'h1);
        wr(PWC_OFS_DUTY, 32'h0000_2000);
        wt(350);
        runs(16'h0019, 16'h004B);
        // sync to a period start, then a deferred pair must wait for its end
        @(posedge pwm_out);
        wr(PWC_OFS_CTRL, 32'h0000_003F);
        wr(PWC_OFS_PAIR, 32'h0008_4000);
        rd(PWC_OFS_PAIR, d);
        chk("deferred pair held", d, 32'h0064_0019);
        wt(200);
        rd(PWC_OFS_PAIR, d);
        chk("deferred pair applied", d, 32'h0008_0004);
        wt(40);
        runs(16'h0004, 16'h0004);
        tally_and_finish();
    end
endmodule
`default_nettype wire
